// [rtu_pkg.sv]
// Shared constants and types for the RTU slave frame handler.
// Assumes a single 40 MHz core clock; the half-bit divider function is shared as well.
package rtu_pkg;

  // Core clock rate
  localparam int CLK_HZ = 40_000_000;

  // Selectable bit rates, index is the baud select field
  localparam int BAUD_0 = 2400;
  localparam int BAUD_1 = 4800;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 19200;
  localparam int BAUD_4 = 38400;
  localparam int BAUD_5 = 115200;

  // Character and gap timing, in half-bit periods; character length in bits, shortest frame in characters
  localparam int          CHAR_BITS   = 11;
  localparam int          CHAR_HALVES = 2 * CHAR_BITS;
  localparam logic [6:0]  GAP15       = 7'(CHAR_HALVES * 3 / 2);
  localparam logic [6:0]  GAP35       = 7'(CHAR_HALVES * 7 / 2);
  localparam logic [4:0]  RX_PAR_HALF = 5'h12;
  localparam logic [4:0]  RX_END_NP   = 5'h12;
  localparam logic [4:0]  RX_END_P    = 5'h14;
  localparam logic [4:0]  TX_END_HALF = 5'(CHAR_HALVES - 1);
  localparam logic [8:0]  MIN_FRAME   = 9'h004;

  // Error check
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_QUERY   = 8'h0c;
  localparam logic [7:0] OFF_TX_DATA = 8'h10;
  localparam logic [7:0] OFF_TX_CTRL = 8'h14;

  // Control register fields and reset values
  localparam int         CTRL_ADDR_LSB = 0;
  localparam int         CTRL_BAUD_LSB = 8;
  localparam int         CTRL_PAR_LSB  = 12;
  localparam logic [7:0] ADDR_RST      = 8'h01;
  localparam logic [2:0] BAUD_RST      = 3'h2;

  // Status and transmit control bits
  localparam int ST_EVENTS   = 6;
  localparam int ST_REPLY    = 8;
  localparam int ST_TX_BUSY  = 9;
  localparam int ST_RX_VALID = 10;
  localparam int TXC_SEND    = 0;
  localparam int TXC_EXC     = 1;
  localparam int TXC_FLUSH   = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PAR_EVEN = 2'h0, PAR_ODD = 2'h1, PAR_NONE = 2'h2} parity_t;
  typedef enum logic [1:0] {FS_SYNC = 2'h0, FS_IDLE = 2'h1, FS_BODY = 2'h3,
                            FS_HOLD = 2'h2} frame_state_t;
  typedef enum logic [1:0] {TS_IDLE = 2'h0, TS_WAIT = 2'h1, TS_LOAD = 2'h3,
                            TS_CHAR = 2'h2} tx_state_t;

  // Clock cycles per half bit for a baud select value
  function automatic logic [13:0] half_div(input logic [2:0] sel);
    int b;
    case (sel)
      3'h0:    b = BAUD_0;
      3'h1:    b = BAUD_1;
      3'h2:    b = BAUD_2;
      3'h3:    b = BAUD_3;
      3'h4:    b = BAUD_4;
      default: b = BAUD_5;
    endcase
    return 14'(CLK_HZ / (2 * b));
  endfunction

endpackage

// [rtu_crc16.sv]
// Byte-wise running error-check register for the RTU frame handler.
// Assumes init and en are one-cycle strobes in the core clock domain.
`timescale 1ns/1ps
module rtu_crc16 (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Control and data
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // Result
  output logic      [15:0] crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // Reflected polynomial, one data bit per step, from preset when starting
  always_comb begin
    crc_d = (init ? rtu_pkg::CRC_INIT : crc_q) ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ rtu_pkg::CRC_POLY) : (crc_d >> 1);
    end
  end

  // Register update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= rtu_pkg::CRC_INIT;
    end else if (en) begin
      crc_q <= crc_d;
    end else if (init) begin
      crc_q <= rtu_pkg::CRC_INIT;
    end
  end

  assign crc = crc_q;

endmodule

// [rtu_slave_frame_handler.sv]
// RTU slave frame handler: character send/receive, framing, address filter,
// reply assembly, with an AXI4-Lite register slave.
// Assumes one core clock, line_rx synchronous to it, and an external line driver.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module rtu_slave_frame_handler #(
  parameter int ADDR_W   = 8,
  parameter int TX_DEPTH = 32
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial line
  input  wire logic              line_rx,
  output logic                   line_tx,
  output logic                   line_tx_en
);

  localparam int CW = $clog2(TX_DEPTH + 1);
  localparam int IW = CW + 2;
  localparam int BW = $clog2(TX_DEPTH);

  // Register decode shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    return a == rtu_pkg::OFF_CTRL || a == rtu_pkg::OFF_STATUS || a == rtu_pkg::OFF_RX_DATA ||
           a == rtu_pkg::OFF_QUERY || a == rtu_pkg::OFF_TX_DATA || a == rtu_pkg::OFF_TX_CTRL;
  endfunction

  logic [7:0]           own_addr_q;
  logic [2:0]           baud_sel_q;
  rtu_pkg::parity_t     parity_q;
  logic [13:0]          hdiv;
  logic [13:0]          fdiv_q;
  logic                 half_tick;
  logic [6:0]           gap_q;
  logic                 rx_busy_q;
  logic [13:0]          rdiv_q;
  logic [4:0]           rhalf_q;
  logic [7:0]           rsh_q;
  logic                 rpar_q;
  logic                 rbad_q;
  logic                 rx_done_q;
  logic                 rx_cerr_q;
  logic [4:0]           rlast;
  rtu_pkg::frame_state_t fs_q;
  logic [8:0]           cnt_q;
  logic                 for_us_q;
  logic                 cacc_q;
  logic [7:0]           qaddr_q;
  logic [7:0]           func_q;
  logic                 reply_ok_q;
  logic [7:0]           rx_data_q;
  logic                 rx_first_q;
  logic                 rx_valid_q;
  logic                 addr_hit;
  logic [15:0]          rx_crc;
  logic [rtu_pkg::ST_EVENTS-1:0] ev_q;
  logic [rtu_pkg::ST_EVENTS-1:0] st_q;
  rtu_pkg::tx_state_t   ts_q;
  logic [7:0]           txbuf [TX_DEPTH];
  logic [CW-1:0]        tcnt_q;
  logic [IW-1:0]        tidx_q;
  logic [IW-1:0]        tlen;
  logic                 texc_q;
  logic [10:0]          tsh_q;
  logic [4:0]           thalf_q;
  logic [7:0]           tx_byte;
  logic                 tx_par;
  logic [15:0]          tx_crc;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [7:0]           aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 wr_fire;
  logic                 rd_fire;
  logic [7:0]           ar_addr;

  assign hdiv      = rtu_pkg::half_div(baud_sel_q);
  assign half_tick = fdiv_q >= hdiv - 14'h0001;
  assign rlast     = (parity_q == rtu_pkg::PAR_NONE) ? rtu_pkg::RX_END_NP : rtu_pkg::RX_END_P;
  assign addr_hit  = rsh_q == own_addr_q || rsh_q == 8'h00;
  assign tlen      = IW'(tcnt_q) + IW'(4);
  assign wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign ar_addr   = 8'(s_axi_araddr);

  // Free-running half-bit divider for gap timing and sending
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fdiv_q <= 14'h0000;
    end else if (half_tick) begin
      fdiv_q <= 14'h0000;
    end else begin
      fdiv_q <= fdiv_q + 14'h0001;
    end
  end

  // Silence timer, restarted by any line activity in either direction
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 7'h00;
    end else if (rx_busy_q || !line_rx || line_tx_en) begin
      gap_q <= 7'h00;
    end else if (half_tick && gap_q != rtu_pkg::GAP35) begin
      gap_q <= gap_q + 7'h01;
    end
  end

  // Character receiver, realigned on each start edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_busy_q <= 1'b0;
      rdiv_q    <= 14'h0000;
      rhalf_q   <= 5'h00;
      rsh_q     <= 8'h00;
      rpar_q    <= 1'b0;
      rbad_q    <= 1'b0;
      rx_done_q <= 1'b0;
      rx_cerr_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!line_rx && !line_tx_en) begin
          rx_busy_q <= 1'b1;
          rdiv_q    <= 14'h0000;
          rhalf_q   <= 5'h00;
          rpar_q    <= 1'b0;
          rbad_q    <= 1'b0;
        end
      end else if (rdiv_q >= hdiv - 14'h0001) begin
        rdiv_q  <= 14'h0000;
        rhalf_q <= rhalf_q + 5'h01;
        if (rhalf_q == 5'h00 && line_rx) begin
          rx_busy_q <= 1'b0;
        end else if (!rhalf_q[0] && rhalf_q >= 5'h02 && rhalf_q <= 5'h10) begin
          rsh_q  <= {line_rx, rsh_q[7:1]};
          rpar_q <= rpar_q ^ line_rx;
        end else if (rhalf_q == rtu_pkg::RX_PAR_HALF && parity_q != rtu_pkg::PAR_NONE) begin
          rbad_q <= (rpar_q ^ line_rx) != (parity_q == rtu_pkg::PAR_ODD);
        end
        if (rhalf_q == rlast) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= 1'b1;
          rx_cerr_q <= rbad_q || !line_rx;
        end
      end else begin
        rdiv_q <= rdiv_q + 14'h0001;
      end
    end
  end

  // Running check over received frame
  rtu_crc16 u_rx_crc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .init     (rx_done_q && fs_q == rtu_pkg::FS_IDLE),
    .en       (rx_done_q),
    .data     (rsh_q),
    .crc      (rx_crc)
  );

  // Frame tracker: sync, wait for address, body, post-frame hold
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fs_q       <= rtu_pkg::FS_SYNC;
      cnt_q      <= 9'h000;
      for_us_q   <= 1'b0;
      cacc_q     <= 1'b0;
      qaddr_q    <= 8'h00;
      func_q     <= 8'h00;
      reply_ok_q <= 1'b0;
      ev_q       <= '0;
    end else begin
      ev_q <= '0;
      if (ts_q == rtu_pkg::TS_CHAR && half_tick && thalf_q == rtu_pkg::TX_END_HALF &&
          tidx_q == tlen - IW'(1)) begin
        reply_ok_q <= 1'b0;
      end
      case (fs_q)
        rtu_pkg::FS_SYNC: begin
          if (gap_q == rtu_pkg::GAP35) begin
            fs_q <= rtu_pkg::FS_IDLE;
          end
        end
        rtu_pkg::FS_IDLE: begin
          if (rx_done_q) begin
            fs_q       <= rtu_pkg::FS_BODY;
            cnt_q      <= 9'h001;
            for_us_q   <= addr_hit;
            qaddr_q    <= rsh_q;
            cacc_q     <= rx_cerr_q;
            reply_ok_q <= 1'b0;
          end
        end
        rtu_pkg::FS_BODY: begin
          if (rx_done_q) begin
            if (cnt_q != 9'h1ff) begin
              cnt_q <= cnt_q + 9'h001;
            end
            if (cnt_q == 9'h001) begin
              func_q <= rsh_q;
            end
            cacc_q <= cacc_q | rx_cerr_q;
          end else if (gap_q == rtu_pkg::GAP15) begin
            fs_q    <= rtu_pkg::FS_HOLD;
            ev_q[2] <= cnt_q < rtu_pkg::MIN_FRAME;
            ev_q[3] <= cnt_q >= rtu_pkg::MIN_FRAME && rx_crc != 16'h0000;
            ev_q[4] <= cacc_q;
            if (for_us_q && cnt_q >= rtu_pkg::MIN_FRAME && rx_crc == 16'h0000 && !cacc_q) begin
              ev_q[0]    <= 1'b1;
              ev_q[1]    <= qaddr_q == 8'h00;
              reply_ok_q <= qaddr_q != 8'h00;
            end
          end
        end
        default: begin
          if (rx_done_q) begin
            fs_q       <= rtu_pkg::FS_SYNC;
            reply_ok_q <= 1'b0;
            ev_q[3]    <= 1'b1;
          end else if (gap_q == rtu_pkg::GAP35) begin
            fs_q <= rtu_pkg::FS_IDLE;
          end
        end
      endcase
      if (rx_done_q && rx_valid_q && !rd_fire &&
          ((fs_q == rtu_pkg::FS_IDLE && addr_hit) || (fs_q == rtu_pkg::FS_BODY && for_us_q))) begin
        ev_q[5] <= 1'b1;
      end
    end
  end

  // Received byte hand-off to software, cleared by reading it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_q  <= 8'h00;
      rx_first_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end else if (rx_done_q &&
        ((fs_q == rtu_pkg::FS_IDLE && addr_hit) || (fs_q == rtu_pkg::FS_BODY && for_us_q))) begin
      rx_data_q  <= rsh_q;
      rx_first_q <= fs_q == rtu_pkg::FS_IDLE;
      rx_valid_q <= 1'b1;
    end else if (rd_fire && ar_addr == rtu_pkg::OFF_RX_DATA) begin
      rx_valid_q <= 1'b0;
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (wr_fire && aw_addr_q == rtu_pkg::OFF_STATUS && w_strb_q[0]) begin
      st_q <= (st_q & ~w_data_q[rtu_pkg::ST_EVENTS-1:0]) | ev_q;
    end else begin
      st_q <= st_q | ev_q;
    end
  end

  // Line format and station settings
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      own_addr_q <= rtu_pkg::ADDR_RST;
      baud_sel_q <= rtu_pkg::BAUD_RST;
      parity_q   <= rtu_pkg::PAR_EVEN;
    end else if (wr_fire && aw_addr_q == rtu_pkg::OFF_CTRL) begin
      if (w_strb_q[0]) begin
        own_addr_q <= w_data_q[rtu_pkg::CTRL_ADDR_LSB +: 8];
      end
      if (w_strb_q[1]) begin
        baud_sel_q <= w_data_q[rtu_pkg::CTRL_BAUD_LSB +: 3];
        parity_q   <= rtu_pkg::parity_t'(w_data_q[rtu_pkg::CTRL_PAR_LSB +: 2]);
      end
    end
  end

  // Reply byte sequence: address, function, data, check low, check high
  always_comb begin
    if (tidx_q == IW'(0)) begin
      tx_byte = own_addr_q;
    end else if (tidx_q == IW'(1)) begin
      tx_byte = {func_q[7] | texc_q, func_q[6:0]};
    end else if (tidx_q < tlen - IW'(2)) begin
      tx_byte = txbuf[BW'(tidx_q - IW'(2))];
    end else if (tidx_q == tlen - IW'(2)) begin
      tx_byte = tx_crc[7:0];
    end else begin
      tx_byte = tx_crc[15:8];
    end
    tx_par = ^tx_byte ^ (parity_q == rtu_pkg::PAR_ODD);
  end

  // Running check over sent frame
  rtu_crc16 u_tx_crc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .init     (ts_q == rtu_pkg::TS_LOAD && half_tick && tidx_q == IW'(0)),
    .en       (ts_q == rtu_pkg::TS_LOAD && half_tick && tidx_q < tlen - IW'(2)),
    .data     (tx_byte),
    .crc      (tx_crc)
  );

  // Reply data buffer, filled by software while idle
  always_ff @(posedge core_clk) begin
    if (wr_fire && aw_addr_q == rtu_pkg::OFF_TX_DATA && w_strb_q[0] &&
        ts_q == rtu_pkg::TS_IDLE && tcnt_q < CW'(TX_DEPTH)) begin
      txbuf[tcnt_q[$clog2(TX_DEPTH)-1:0]] <= w_data_q[7:0];
    end
  end

  // Transmitter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ts_q       <= rtu_pkg::TS_IDLE;
      tcnt_q     <= '0;
      tidx_q     <= '0;
      texc_q     <= 1'b0;
      tsh_q      <= 11'h7ff;
      thalf_q    <= 5'h00;
      line_tx_en <= 1'b0;
    end else begin
      case (ts_q)
        rtu_pkg::TS_IDLE: begin
          if (wr_fire && aw_addr_q == rtu_pkg::OFF_TX_DATA && w_strb_q[0] &&
              tcnt_q < CW'(TX_DEPTH)) begin
            tcnt_q <= tcnt_q + CW'(1);
          end else if (wr_fire && aw_addr_q == rtu_pkg::OFF_TX_CTRL && w_strb_q[0]) begin
            if (w_data_q[rtu_pkg::TXC_FLUSH]) begin
              tcnt_q <= '0;
            end else if (w_data_q[rtu_pkg::TXC_SEND] && reply_ok_q) begin
              ts_q   <= rtu_pkg::TS_WAIT;
              texc_q <= w_data_q[rtu_pkg::TXC_EXC];
            end
          end
        end
        rtu_pkg::TS_WAIT: begin
          if (!reply_ok_q) begin
            ts_q <= rtu_pkg::TS_IDLE;
          end else if (fs_q == rtu_pkg::FS_IDLE && !rx_busy_q && line_rx) begin
            ts_q   <= rtu_pkg::TS_LOAD;
            tidx_q <= '0;
          end
        end
        rtu_pkg::TS_LOAD: begin
          if (half_tick) begin
            line_tx_en <= 1'b1;
            thalf_q    <= 5'h00;
            ts_q       <= rtu_pkg::TS_CHAR;
            if (parity_q == rtu_pkg::PAR_NONE) begin
              tsh_q <= {2'b11, tx_byte, 1'b0};
            end else begin
              tsh_q <= {1'b1, tx_par, tx_byte, 1'b0};
            end
          end
        end
        default: begin
          if (half_tick) begin
            thalf_q <= thalf_q + 5'h01;
            if (thalf_q[0]) begin
              tsh_q <= {1'b1, tsh_q[10:1]};
            end
            if (thalf_q == rtu_pkg::TX_END_HALF) begin
              tidx_q <= tidx_q + IW'(1);
              ts_q   <= rtu_pkg::TS_LOAD;
              if (tidx_q == tlen - IW'(1)) begin
                ts_q       <= rtu_pkg::TS_IDLE;
                line_tx_en <= 1'b0;
                tcnt_q     <= '0;
              end
            end
          end
        end
      endcase
    end
  end

  assign line_tx = tsh_q[0];

  // AXI write address and data, taken in either order
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rtu_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= 8'(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_q) ? rtu_pkg::RESP_OKAY : rtu_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read: one outstanding, data captured at address handshake
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= rtu_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(ar_addr) ? rtu_pkg::RESP_OKAY : rtu_pkg::RESP_SLVERR;
      case (ar_addr)
        rtu_pkg::OFF_CTRL:    s_axi_rdata <= {18'h00000, parity_q, 1'b0, baud_sel_q, own_addr_q};
        rtu_pkg::OFF_STATUS:  s_axi_rdata <= {21'h000000, rx_valid_q, ts_q != rtu_pkg::TS_IDLE,
                                                reply_ok_q, 2'b00, st_q};
        rtu_pkg::OFF_RX_DATA: s_axi_rdata <= {22'h000000, rx_valid_q, rx_first_q, rx_data_q};
        rtu_pkg::OFF_QUERY:   s_axi_rdata <= {7'h00, cnt_q, qaddr_q, func_q};
        rtu_pkg::OFF_TX_CTRL: s_axi_rdata <= 32'(tcnt_q);
        default:              s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [rtu_slave_frame_handler_props.sv]
// Checker for the RTU slave frame handler's bus and line ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module rtu_slave_frame_handler_props #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and handshakes
  input wire logic              core_clk, resetn, s_axi_arvalid, s_axi_arready,
  input wire logic              s_axi_rvalid, s_axi_rready, s_axi_bvalid, s_axi_bready,
  // Read payload and serial output
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              line_tx, line_tx_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Reply frame opens, and a character begins on the driven line
  sequence tx_open;
    $rose(line_tx_en);
  endsequence
  sequence char_start;
    line_tx_en && $fell(line_tx);
  endsequence
  // Read address taken, and taken for an address above the map
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h14;
  endsequence
  a_idle_high: assert property (!line_tx_en |-> line_tx)
    else $error("line low while not driving");
  a_frame_held: assert property (tx_open |-> line_tx_en [*8])
    else $error("driver enable dropped early");
  a_start_bit: assert property (char_start |-> !line_tx [*8])
    else $error("start bit too short");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer not held");
  a_read_unmapped: assert property (rd_bad |=> s_axi_rresp == rtu_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule

// [rtu_master_model.sv]
// Behavioural bus master that sends query frames on the slave's receive line.
// Assumes the slave is set to no parity and the fastest bit rate.
`timescale 1ns/1ps
module rtu_master_model (
  // Clock and line
  input wire logic core_clk,
  output logic     line_rx
);
  localparam int HALF = rtu_pkg::CLK_HZ / (2 * rtu_pkg::BAUD_5);
  // Line idles high between frames
  initial line_rx = 1'b1;
  // One character: start, data LSB first, two stops without parity
  task automatic send_char(input logic [7:0] c);
    logic [10:0] bits;
    bits = {2'b11, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_rx <= bits[i];
      repeat (2 * HALF) @(posedge core_clk);
    end
  endtask
  // Query of address and function, then check low byte first
  task automatic send_frame(input logic [7:0] a, input logic [7:0] f);
    logic [15:0] crc;
    logic [7:0]  b [2];
    crc = 16'hffff;
    b[0] = a;
    b[1] = f;
    for (int k = 0; k < 2; k++) begin
      crc ^= {8'h00, b[k]};
      for (int j = 0; j < 8; j++) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
    end
    send_char(a);
    send_char(f);
    send_char(crc[7:0]);
    send_char(crc[15:8]);
  endtask
endmodule

// [test_rtu_slave_frame_handler.sv]
// Self-checking bench: registers over AXI4-Lite, queries from the master model.
// Assumes the checker and master model files are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_rtu_slave_frame_handler;
  localparam int HALF = rtu_pkg::CLK_HZ / (2 * rtu_pkg::BAUD_5);
  logic core_clk, resetn, line_rx, line_tx, line_tx_en, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          fail_count, num_checks;
  rtu_slave_frame_handler u_rtu_slave_frame_handler (.*);
  rtu_master_model u_rtu_master_model (.core_clk(core_clk), .line_rx(line_rx));
  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_halves(input int k);
    repeat (k * HALF) @(posedge core_clk);
  endtask
  // Bus write: hold each channel until taken, then wait for the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, rtu_pkg::RESP_OKAY)
    if (n == 64) begin
      fail_count++;
      print_verdict();
    end
    @(posedge core_clk);
  endtask
  // Bus read: result lands in rd and rsp
  task automatic axi_rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 64) begin
      fail_count++;
      print_verdict();
    end
    @(posedge core_clk);
  endtask
  // Reset format, unmapped access, then station 05 at top rate, no parity
  task automatic check_config();
    axi_rd(rtu_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_0201)
    axi_rd(8'h40);
    `CHK({rsp, rd}, {rtu_pkg::RESP_SLVERR, 32'h0})
    axi_wr(rtu_pkg::OFF_CTRL, 32'h0000_2505);
    axi_rd(rtu_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_2505)
    wait_halves(80);
  endtask
  // Broadcast is taken but a send request must stay silent
  task automatic check_broadcast();
    logic seen;
    u_rtu_master_model.send_frame(8'h00, 8'h03);
    wait_halves(40);
    axi_rd(rtu_pkg::OFF_STATUS);
    `CHK(rd & 32'h106, 32'h002)
    axi_wr(rtu_pkg::OFF_TX_CTRL, 32'h1);
    seen = 1'b0;
    repeat (50 * HALF) begin
      @(posedge core_clk);
      seen = seen | line_tx_en;
    end
    `CHK(seen, 1'b0)
  endtask
  // Lone byte is a partial frame; own query is flagged, reply echoes address and function
  task automatic check_query();
    logic [10:0] ch;
    int          n;
    axi_wr(rtu_pkg::OFF_STATUS, 32'h3f);
    u_rtu_master_model.send_char(8'h05);
    wait_halves(80);
    axi_rd(rtu_pkg::OFF_STATUS);
    `CHK(rd & 32'h105, 32'h004)
    axi_wr(rtu_pkg::OFF_STATUS, 32'h3f);
    u_rtu_master_model.send_frame(8'h05, 8'h03);
    wait_halves(40);
    axi_rd(rtu_pkg::OFF_STATUS);
    `CHK(rd & 32'h105, 32'h101)
    axi_wr(rtu_pkg::OFF_TX_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      for (n = 0; n < 20000 && line_tx !== 1'b0; n++) @(posedge core_clk);
      if (n == 20000) begin
        fail_count++;
        print_verdict();
      end
      wait_halves(1);
      for (n = 0; n < 11; n++) begin
        ch[n] = line_tx;
        wait_halves(2);
      end
      `CHK(ch, {2'b11, ((k == 0) ? 8'h05 : 8'h03), 1'b0})
    end
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    check_config();
    check_broadcast();
    check_query();
    print_verdict();
  end
endmodule
bind rtu_slave_frame_handler rtu_slave_frame_handler_props #(.ADDR_W(ADDR_W)) u_props (.*);
